// >>> aosc_pkg.sv
// constants, register map and types for the analog output sampling controller
package aosc_pkg;
   localparam int unsigned CH_NUM       = 16;          // analog output channels
   localparam int unsigned CODE_W       = 16;          // sample code width
   localparam int unsigned BUF_DEPTH    = 1024;        // sample buffer words
   localparam int unsigned PTR_W        = 10;          // buffer pointer width
   localparam int unsigned CNT_W        = 11;          // buffer fill width
   localparam int unsigned ADDR_W       = 8;           // register byte address width
   localparam logic [CODE_W-1:0] CODE_ZERO_V = 16'h8000; // offset binary mid-scale

   // timing
   localparam int unsigned CLK_MHZ      = 100;         // reference clock rate
   localparam int unsigned FILT_NS      = 1000;        // least accepted pulse width
   localparam int unsigned FILT_CYC     = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  FILT_LAST    = 8'(FILT_CYC - 1);

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00; // mode and source selects
   localparam logic [ADDR_W-1:0] REG_CMD       = 8'h04; // start / stop / clear strobes
   localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h08; // run state and fill
   localparam logic [ADDR_W-1:0] REG_SMP_TGT   = 8'h0C; // samples before count stop
   localparam logic [ADDR_W-1:0] REG_CLK_DIV   = 8'h10; // internal pacing period
   localparam logic [ADDR_W-1:0] REG_BUF_DATA  = 8'h14; // buffer push port
   localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h18; // sticky events, write one to clear
   localparam logic [ADDR_W-1:0] REG_INT_MASK  = 8'h1C; // interrupt enables
   localparam logic [ADDR_W-1:0] REG_SMP_DONE  = 8'h20; // samples output so far

   // control field positions
   localparam int unsigned CTL_START_EXT = 0;
   localparam int unsigned CTL_STOP_LO   = 1;   // two-bit stop select
   localparam int unsigned CTL_CLK_EXT   = 3;
   localparam int unsigned CTL_START_FALL= 4;
   localparam int unsigned CTL_STOP_FALL = 5;
   localparam int unsigned CTL_CLK_FALL  = 6;
   localparam int unsigned CTL_FILT_EN   = 7;
   localparam int unsigned CTL_RING      = 8;
   localparam int unsigned CTL_CH_LO     = 9;   // four-bit channel count minus one
   localparam int unsigned CTL_W         = 13;
   localparam logic [CTL_W-1:0] CTL_RESET = 13'h0000;

   // command bits
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_STOP  = 1;
   localparam int unsigned CMD_CLEAR = 2;

   // stop selects
   localparam logic [1:0] STOP_COUNT = 2'h0;
   localparam logic [1:0] STOP_EXT   = 2'h1;

   // interrupt bits
   localparam int unsigned EV_START   = 0;
   localparam int unsigned EV_STOP    = 1;
   localparam int unsigned EV_SAMPLE  = 2;
   localparam int unsigned EV_UNDER   = 3;
   localparam int unsigned EV_OVER    = 4;
   localparam int unsigned EV_W       = 5;

   localparam logic [31:0] DIV_RESET  = 32'h0000_03E8; // 10 us pace by default
   localparam int unsigned FILL_LO    = 16;            // fill field in status

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} aosc_state_type;
endpackage

// >>> aosc_top.sv
// analog output sampling controller: triggers, pacing, sample buffer, channel outputs
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps

module aosc_top
   import aosc_pkg::*;
(
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_reset,
   input  wire logic [ADDR_W-1:0]            i_addr,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic                         i_wr,
   input  wire logic                         i_rd,
   output logic      [31:0]                  o_rdata,
   output logic                              o_irq,
   input  wire logic                         i_ext_start_trigger_in,
   input  wire logic                         i_ext_stop_trigger_in,
   input  wire logic                         i_ext_sample_clock_in,
   output logic      [CH_NUM-1:0][CODE_W-1:0] o_analog_out_channel,
   output logic                              o_update,
   output logic                              o_running
);
   // address decode helper, used by both strobes
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   logic [CTL_W-1:0]   ctrl_q;          // configuration
   logic [31:0]        tgt_q;           // sample target for count stop
   logic [31:0]        div_q;           // internal pacing period in cycles
   logic [31:0]        done_q;          // samples output
   logic [EV_W-1:0]    ist_q;           // sticky event bits
   logic [EV_W-1:0]    imask_q;         // event enables
   logic [31:0]        rdata_q;         // read data, valid one cycle after strobe
   logic               irq_q, run_q;    // interrupt level, registered run flag
   aosc_state_type     state_q;
   logic [CODE_W-1:0]  mem [BUF_DEPTH]; // sample buffer
   logic [PTR_W-1:0]   wp_q;
   logic [PTR_W-1:0]   rp_q;
   logic [CNT_W-1:0]   fill_q;
   logic               busy_q;          // channel sweep in progress
   logic [3:0]         ch_q;            // channel being loaded
   logic [CH_NUM-1:0][CODE_W-1:0] chan_q;
   logic               upd_q;
   logic [31:0]        pace_q;          // internal divider count
   logic               sc_s1_q, sc_s2_q, sc_s3_q; // sample clock synchroniser

   // register strobes
   wire wr_ctrl  = i_wr & hit(i_addr, REG_CTRL);
   wire wr_cmd   = i_wr & hit(i_addr, REG_CMD);
   wire wr_tgt   = i_wr & hit(i_addr, REG_SMP_TGT);
   wire wr_div   = i_wr & hit(i_addr, REG_CLK_DIV);
   wire wr_buf   = i_wr & hit(i_addr, REG_BUF_DATA);
   wire wr_ist   = i_wr & hit(i_addr, REG_INT_STAT);
   wire wr_imask = i_wr & hit(i_addr, REG_INT_MASK);
   wire cmd_start = wr_cmd & i_wdata[CMD_START];
   wire cmd_stop  = wr_cmd & i_wdata[CMD_STOP];
   wire cmd_clear = wr_cmd & i_wdata[CMD_CLEAR];

   // control fields
   wire       start_ext = ctrl_q[CTL_START_EXT];
   wire [1:0] stop_sel  = ctrl_q[CTL_STOP_LO +: 2];
   wire       clk_ext   = ctrl_q[CTL_CLK_EXT];
   wire       filt_en   = ctrl_q[CTL_FILT_EN];
   wire       ring      = ctrl_q[CTL_RING];
   wire [3:0] ch_last   = ctrl_q[CTL_CH_LO +: 4];
   wire [1:0] trig_fall = {ctrl_q[CTL_STOP_FALL], ctrl_q[CTL_START_FALL]};

   // trigger inputs: synchroniser, chatter filter, polarity edge detect
   wire [1:0] trig_pin = {i_ext_stop_trigger_in, i_ext_start_trigger_in};
   wire [1:0] trig_edge;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_trig
         logic       s1_q, s2_q;   // two-stage synchroniser
         logic       lvl_q;        // accepted level
         logic       prev_q;       // accepted level, last cycle
         logic [7:0] cnt_q;        // cycles the pin disagreed with lvl_q
         wire        differ   = (s2_q != lvl_q);
         wire        settled  = differ & (cnt_q == FILT_LAST);
         // short pulses restart the count, so only a 1 us steady level is taken
         always_ff @(posedge i_ref_clk)
         begin
            s1_q <= trig_pin[g];
            s2_q <= s1_q;
            if (i_reset)
            begin
               lvl_q  <= 1'b0;
               prev_q <= 1'b0;
               cnt_q  <= 8'h00;
            end
            else
            begin
               prev_q <= lvl_q;
               if (!filt_en)                   // bypass: follow the pin
               begin
                  lvl_q <= s2_q;
                  cnt_q <= 8'h00;
               end
               else if (settled)
               begin
                  lvl_q <= s2_q;
                  cnt_q <= 8'h00;
               end
               else if (differ)
                  cnt_q <= cnt_q + 8'h01;
               else
                  cnt_q <= 8'h00;              // glitch ended early, rejected
            end
         end
         // active edge per polarity select
         assign trig_edge[g] = (lvl_q ^ trig_fall[g]) & ~(prev_q ^ trig_fall[g]);
      end
   endgenerate
   wire start_edge = trig_edge[0];
   wire stop_edge  = trig_edge[1];

   // sample clock: synchroniser only, no filter so pacing edges are not delayed
   always_ff @(posedge i_ref_clk)
   begin
      sc_s1_q <= i_ext_sample_clock_in;
      sc_s2_q <= sc_s1_q;
      sc_s3_q <= sc_s2_q;
   end
   wire clk_fall = ctrl_q[CTL_CLK_FALL];
   wire ext_tick = (sc_s2_q ^ clk_fall) & ~(sc_s3_q ^ clk_fall);
   wire int_tick = (pace_q >= div_q - 32'h1);
   wire tick     = (state_q == ST_RUN) & (clk_ext ? ext_tick : int_tick);

   // buffer status and sweep decode
   wire buf_full  = (fill_q == CNT_W'(BUF_DEPTH));
   wire buf_empty = (fill_q == '0);
   wire push      = wr_buf & ~buf_full & ~cmd_clear;
   wire overflow  = wr_buf & buf_full;
   wire step      = busy_q & ~buf_empty & (state_q == ST_RUN);
   wire underrun  = busy_q & buf_empty & (state_q == ST_RUN);
   wire pop       = step & ~ring;
   wire last_ch   = (ch_q == ch_last);
   wire smp_end   = step & last_ch;
   wire [PTR_W-1:0] rp_inc   = rp_q + PTR_W'(1);
   wire [PTR_W-1:0] rp_next  = (ring && rp_inc == wp_q) ? '0 : rp_inc;
   wire cnt_stop  = smp_end & (stop_sel == STOP_COUNT) & (done_q + 32'h1 == tgt_q);
   wire ext_stop  = stop_edge & (stop_sel == STOP_EXT) & (state_q == ST_RUN);
   wire go_run    = ~cmd_stop & ((state_q == ST_IDLE & cmd_start & ~start_ext) |
                    (state_q == ST_ARMED & start_edge));
   wire go_idle   = (state_q != ST_IDLE) & (cmd_stop | cnt_stop | ext_stop | underrun);
   wire [EV_W-1:0] ev = {overflow, underrun, smp_end, go_idle, go_run & ~cmd_stop};

   // run state machine; a software stop wins over any start
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         state_q <= ST_IDLE;
      else if (go_idle)
         state_q <= ST_IDLE;
      else if (go_run)
         state_q <= ST_RUN;
      else if (state_q == ST_IDLE && cmd_start && start_ext && !cmd_stop)
         state_q <= ST_ARMED;
   end

   // internal pacing divider, restarts outside a run
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset || state_q != ST_RUN || int_tick)
         pace_q <= 32'h0;
      else
         pace_q <= pace_q + 32'h1;
   end

   // buffer write side; push and pop may meet in one cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem[wp_q] <= i_wdata[CODE_W-1:0];
   end

   // pointers and fill; ring mode replays without consuming
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset || cmd_clear)
      begin
         wp_q   <= '0;
         rp_q   <= '0;
         fill_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + PTR_W'(1);
         if (step)
            rp_q <= rp_next;
         fill_q <= fill_q + CNT_W'(push) - CNT_W'(pop);
      end
   end

   // channel sweep: one word per cycle into channels 0..ch_last, then update
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         busy_q <= 1'b0;
         ch_q   <= 4'h0;
         upd_q  <= 1'b0;
         run_q  <= 1'b0;
         done_q <= 32'h0;
         chan_q <= {CH_NUM{CODE_ZERO_V}};
      end
      else
      begin
         upd_q <= smp_end;
         run_q <= ~go_idle & (go_run | (state_q == ST_RUN)); // next state is run
         if (go_run)
            done_q <= 32'h0;
         else if (smp_end)
            done_q <= done_q + 32'h1;
         if (go_idle)                                                     // abort the sweep
         begin
            busy_q <= 1'b0;
            ch_q   <= 4'h0;
         end
         else if (tick && !busy_q)
            busy_q <= 1'b1;
         else if (step)
         begin
            ch_q   <= last_ch ? 4'h0 : ch_q + 4'h1;
            busy_q <= ~last_ch;
         end
         if (step)
            chan_q[ch_q] <= mem[rp_q];
      end
   end

   // configuration registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ctrl_q  <= CTL_RESET;
         tgt_q   <= 32'h0;
         div_q   <= DIV_RESET;
         imask_q <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= i_wdata[CTL_W-1:0];
         if (wr_tgt)
            tgt_q <= i_wdata;
         if (wr_div)
            div_q <= (i_wdata == 32'h0) ? 32'h1 : i_wdata;                // zero would stall
         if (wr_imask)
            imask_q <= i_wdata[EV_W-1:0];
      end
   end

   // sticky events: a new event outlives a clear in the same cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ist_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         ist_q <= (ist_q & ~(wr_ist ? i_wdata[EV_W-1:0] : '0)) | ev;
         irq_q <= |(ist_q & imask_q);
      end
   end

   // read mux, unmapped offsets read zero
   wire [31:0] status_w = {5'h0, fill_q, 14'h0, state_q == ST_ARMED, state_q == ST_RUN};
   wire [31:0] rd_mux =
      hit(i_addr, REG_CTRL)     ? {19'h0, ctrl_q}   :
      hit(i_addr, REG_STATUS)   ? status_w          :
      hit(i_addr, REG_SMP_TGT)  ? tgt_q             :
      hit(i_addr, REG_CLK_DIV)  ? div_q             :
      hit(i_addr, REG_INT_STAT) ? {27'h0, ist_q}    :
      hit(i_addr, REG_INT_MASK) ? {27'h0, imask_q}  :
      hit(i_addr, REG_SMP_DONE) ? done_q            : 32'h0;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         rdata_q <= 32'h0;
      else
         rdata_q <= i_rd ? rd_mux : 32'h0;
   end
   assign o_rdata              = rdata_q;
   assign o_irq                = irq_q;
   assign o_analog_out_channel = chan_q;
   assign o_update             = upd_q;
   assign o_running            = run_q;
   // checks
   sequence sweep_s;
      tick && !busy_q && !go_idle ##1 busy_q;
   endsequence
   start_sw_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (state_q == ST_IDLE && cmd_start && !cmd_stop && !start_ext) |=> o_running)
      else $error("software start did not run");
   stop_sw_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmd_stop |=> state_q == ST_IDLE)
      else $error("software stop ignored");
   stop_cnt_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cnt_stop |=> !o_running && ist_q[EV_STOP])
      else $error("count stop missed");
   pace_int_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_running && !clk_ext && !busy_q && int_tick && !go_idle) |=> busy_q)
      else $error("internal tick lost");
   filt_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      ($past(filt_en) && $changed(g_trig[0].lvl_q)) |-> $past(g_trig[0].cnt_q) == FILT_LAST)
      else $error("trigger filter accepted short pulse");
   sweep_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      sweep_s |-> ##[0:16] (!busy_q))
      else $error("sweep did not finish");
   ring_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (ring && step && !push && !cmd_clear) |=> $stable(fill_q))
      else $error("ring mode consumed data");
   irq_lvl_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (|(ist_q & imask_q)) |=> o_irq)
      else $error("interrupt not raised");
   under_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      underrun |=> ist_q[EV_UNDER] && state_q == ST_IDLE)
      else $error("underrun not flagged");
   upd_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      smp_end |=> o_update ##1 !o_update)
      else $error("update pulse wrong");
endmodule

// >>> aosc_ext_src.sv
// far side model: external start, stop and sample clock sources
`timescale 1ns/10ps

module aosc_ext_src
(
   input  wire logic i_ref_clk,
   output logic      o_start,
   output logic      o_stop,
   output logic      o_clk
);
   logic [2:0] pins_q; // 0 start, 1 stop, 2 sample clock

   assign o_start = pins_q[0];
   assign o_stop  = pins_q[1];
   assign o_clk   = pins_q[2];

   initial pins_q = 3'h0; // all lines idle low at power-up

   // set an idle level; a falling active edge needs a high idle
   task automatic lvl(input int which, input logic val);
      @(posedge i_ref_clk);
      pins_q[which] <= val;
   endtask

   // invert one line for width cycles, then restore it
   // short widths model chatter; the sample clock is never filtered
   task automatic pulse(input int which, input int width);
      @(posedge i_ref_clk);
      pins_q[which] <= ~pins_q[which];
      repeat (width) @(posedge i_ref_clk);
      pins_q[which] <= ~pins_q[which];
   endtask
endmodule

// >>> analog_output_sampling_control_tb.sv
// self-checking bench for the analog output sampling controller
`timescale 1ns/10ps

module analog_output_sampling_control_tb;
   import aosc_pkg::*;
   logic                           i_ref_clk = 1'b0; // 100 MHz reference
   logic                           i_reset   = 1'b1; // sync reset
   logic [ADDR_W-1:0]              i_addr    = 8'h00;
   logic [31:0]                    i_wdata   = 32'h0;
   logic                           i_wr      = 1'b0;
   logic                           i_rd      = 1'b0;
   logic [31:0]                    o_rdata;
   logic                           o_irq, o_update, o_running;
   logic                           ext_start, ext_stop, ext_clk;
   logic [CH_NUM-1:0][CODE_W-1:0]  o_analog_out_channel;
   logic [CH_NUM-1:0][CODE_W-1:0]  cur;      // expected channel image
   logic [CH_NUM-1:0][CODE_W-1:0]  ch_q[$];  // expected samples
   logic [31:0]                    rd_q[$], msk_q[$]; // expected reads
   logic                           rd_d = 1'b0;
   logic [15:0]                    ring[4];
   int                             n_errors = 0, n_checks = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   aosc_ext_src src (.i_ref_clk(i_ref_clk), .o_start(ext_start), .o_stop(ext_stop),
                     .o_clk(ext_clk));

   aosc_top dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
                 .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
                 .o_irq(o_irq), .i_ext_start_trigger_in(ext_start),
                 .i_ext_stop_trigger_in(ext_stop), .i_ext_sample_clock_in(ext_clk),
                 .o_analog_out_channel(o_analog_out_channel), .o_update(o_update),
                 .o_running(o_running));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // read data stand one cycle after the strobe; compare the oldest note
   always @(posedge i_ref_clk)
   begin
      rd_d <= i_rd;
      if (rd_d === 1'b1)
         chk("read data", rd_q.pop_front(), o_rdata & msk_q.pop_front());
   end

   // each update pulse carries one whole sample on the channels
   always @(posedge i_ref_clk)
   begin
      if (o_update === 1'b1)
      begin
         n_checks++;
         if (ch_q.size() == 0)
         begin
            n_errors++;
            $display("unexpected update: expected none seen %h", o_analog_out_channel);
         end
         else if (o_analog_out_channel !== ch_q[0])
         begin
            n_errors++;
            $display("unexpected channels: expected %h seen %h", ch_q[0],
                     o_analog_out_channel);
         end
         if (ch_q.size() != 0)
            void'(ch_q.pop_front());
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge i_ref_clk);
      rd_q.push_back(e & m);
      msk_q.push_back(m);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
   endtask

   // note a two-channel sample in the expected image
   task automatic note(input logic [15:0] w0, input logic [15:0] w1);
      cur[0] = w0;
      cur[1] = w1;
      ch_q.push_back(cur);
   endtask

   // bounded wait for the monitor to consume every note
   task automatic drain();
      int k;
      for (k = 0; k < 5000 && ch_q.size() != 0; k++) @(posedge i_ref_clk);
      chk("pending samples", 32'h0, 32'(ch_q.size()));
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog sized well above the expected run length
   initial
   begin
      repeat (40000) @(posedge i_ref_clk);
      n_errors++;
      results();
   end

   initial
   begin
      logic [15:0] w0, w1;
      int k;
      void'($urandom(32'h29914984));
      for (k = 0; k < CH_NUM; k++) cur[k] = CODE_ZERO_V;
      repeat (2) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      // power-up state and register defaults
      @(posedge i_ref_clk);
      chk("channels at reset", 32'h1, 32'(o_analog_out_channel === cur));
      chk("running at reset", 32'h0, 32'(o_running));
      rd(REG_CTRL, 32'h0, 32'h1FFF);
      rd(REG_CLK_DIV, DIV_RESET, 32'hFFFF_FFFF);
      wr(8'h3C, 32'h1234_5678);
      rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
      $display("test reset done");
      // software start, internal pace, fifo, count stop, interrupt
      wr(REG_CTRL, 32'h200);
      wr(REG_CLK_DIV, 32'd20);
      wr(REG_SMP_TGT, 32'd2);
      wr(REG_INT_MASK, 32'h0);
      wr(REG_INT_STAT, 32'h1F);
      wr(REG_CMD, 32'h4);
      for (k = 0; k < 2; k++)
      begin
         w0 = 16'($urandom);
         w1 = 16'($urandom);
         wr(REG_BUF_DATA, {16'h0, w0});
         wr(REG_BUF_DATA, {16'h0, w1});
         note(w0, w1);
      end
      wr(REG_CMD, 32'h1);
      drain();
      repeat (10) @(posedge i_ref_clk);
      rd(REG_STATUS, 32'h0, 32'h1);
      rd(REG_SMP_DONE, 32'd2, 32'hFFFF_FFFF);
      rd(REG_INT_STAT, 32'h07, 32'h1F);
      chk("masked irq", 32'h0, 32'(o_irq));
      wr(REG_INT_MASK, 32'h2);
      repeat (2) @(posedge i_ref_clk);
      chk("unmasked irq", 32'h1, 32'(o_irq));
      wr(REG_INT_STAT, 32'h1F);
      repeat (2) @(posedge i_ref_clk);
      chk("cleared irq", 32'h0, 32'(o_irq));
      $display("test count stop done");
      // ring mode, falling filtered start, external clock, rising stop
      src.lvl(0, 1'b1);
      wr(REG_CTRL, 32'h39B);
      wr(REG_CMD, 32'h4);
      for (k = 0; k < 4; k++)
      begin
         ring[k] = 16'($urandom);
         wr(REG_BUF_DATA, {16'h0, ring[k]});
      end
      wr(REG_CMD, 32'h1);
      src.pulse(0, 50);
      repeat (150) @(posedge i_ref_clk);
      rd(REG_STATUS, 32'h2, 32'h3);
      src.pulse(0, 150);
      repeat (20) @(posedge i_ref_clk);
      rd(REG_STATUS, 32'h1, 32'h3);
      for (k = 0; k < 3; k++)
      begin
         note(ring[(2 * k) % 4], ring[(2 * k + 1) % 4]);
         src.pulse(2, 5);
         repeat (35) @(posedge i_ref_clk);
      end
      drain();
      src.pulse(1, 150);
      repeat (20) @(posedge i_ref_clk);
      rd(REG_STATUS, 32'h0, 32'h3);
      rd(REG_SMP_DONE, 32'd3, 32'hFFFF_FFFF);
      $display("test external ring done");
      // software stop only, falling sample clock, ring resumes at word 2
      wr(REG_CTRL, 32'h34C);
      wr(REG_CMD, 32'h1);
      note(ring[2], ring[3]);
      src.pulse(2, 5);
      drain();
      rd(REG_STATUS, 32'h1, 32'h3);
      wr(REG_CMD, 32'h2);
      rd(REG_STATUS, 32'h0, 32'h3);
      rd(REG_SMP_DONE, 32'd1, 32'hFFFF_FFFF);
      // stop and start together: the stop wins
      wr(REG_CMD, 32'h3);
      rd(REG_STATUS, 32'h0, 32'h3);
      $display("test software stop done");
      // empty buffer in mid-sweep, then a full buffer refusing a word
      wr(REG_CTRL, 32'h200);
      wr(REG_CMD, 32'h4);
      wr(REG_INT_STAT, 32'h1F);
      wr(REG_BUF_DATA, 32'h0000_1111);
      wr(REG_CMD, 32'h1);
      repeat (60) @(posedge i_ref_clk);
      rd(REG_INT_STAT, 32'h08, 32'h08);
      rd(REG_STATUS, 32'h0, 32'h1);
      wr(REG_CMD, 32'h4);
      for (k = 0; k < BUF_DEPTH + 1; k++) wr(REG_BUF_DATA, 32'($urandom) & 32'hFFFF);
      rd(REG_INT_STAT, 32'h10, 32'h10);
      rd(REG_STATUS, 32'(BUF_DEPTH) << FILL_LO, 32'h07FF_0000);
      repeat (3) @(posedge i_ref_clk);
      $display("test underrun overflow done");
      results();
   end
endmodule
